// ===== dppa_adapter.sv
// Dual port parallel adapter: host register access, two 8-bit peripheral ports,
// control lines and active-low interrupts.
// Assumes all inputs synchronous to clk; host_en is the processor enable pulse.
// Summary of operation
// [RQ1] No transfer takes place unless the chip-select inputs carry the valid code.
// [RQ2] Every host transfer is timed by the processor enable pulse.
// [RQ3] A byte moves on the host data lines only with select and enable; read/write sets direction.
// [RQ4] There are two independent 8-bit peripheral ports with every line bidirectional.
// [RQ5] Each port A line is input or output per its bit in a host-written direction register.
// [RQ6] Port B behaves like port A but its drivers can be disconnected as a three-state group.
// [RQ7] Two register-select inputs choose the register an access reaches.
// [RQ8] Each port has its own active-low interrupt output for the processor.
// [RQ9] A rising first control input of a port drives that port's interrupt low when enabled.
// [RQ10] The second control line of each port is an interrupt input or a control output per control bit.
// [RQ11] Reset clears all registers to zero, making all lines inputs and disabling interrupts.
// [RQ12] A data read returns the pin for input lines and the stored value for output lines.
`timescale 1ns/1ps

module dppa_adapter (
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  input  wire logic [2:0]                host_cs,
  input  wire logic [1:0]                host_rs,
  input  wire logic                      host_rw,
  input  wire logic                      host_en,
  input  wire logic [dppa_pkg::DPPA_W-1:0] host_data_in,
  output logic      [dppa_pkg::DPPA_W-1:0] host_data_out,
  output logic                           host_data_oe_n,
  input  wire logic [dppa_pkg::DPPA_W-1:0] port_a_lines_in,
  output logic      [dppa_pkg::DPPA_W-1:0] port_a_lines_out,
  output logic      [dppa_pkg::DPPA_W-1:0] port_a_lines_oe_n,
  input  wire logic [dppa_pkg::DPPA_W-1:0] port_b_lines_in,
  output logic      [dppa_pkg::DPPA_W-1:0] port_b_lines_out,
  output logic      [dppa_pkg::DPPA_W-1:0] port_b_lines_oe_n,
  input  wire logic                      port_b_float,
  input  wire logic                      port_a_ctrl_in,
  input  wire logic                      port_b_ctrl_in,
  input  wire logic                      port_a_ctrl_io_in,
  output logic                           port_a_ctrl_io_out,
  output logic                           port_a_ctrl_io_oe_n,
  input  wire logic                      port_b_ctrl_io_in,
  output logic                           port_b_ctrl_io_out,
  output logic                           port_b_ctrl_io_oe_n,
  output logic                           port_a_irq_n,
  output logic                           port_b_irq_n
);
  import dppa_pkg::*;

  typedef struct packed {
    logic [1:0][DPPA_W-1:0]    data;
    logic [1:0][DPPA_W-1:0]    dir;
    logic [1:0][DPPA_CR_W-1:0] ctrl;
    logic                      en_prev;
    logic [DPPA_W-1:0]         hdout;
    logic                      hdoe_n;
    logic [1:0][DPPA_W-1:0]    pout;
    logic [1:0][DPPA_W-1:0]    poe_n;
    logic [1:0]                io_out;
    logic [1:0]                io_oe_n;
    logic [1:0]                irq_n;
  } dppa_state_t;

  // Registers zero, every pin released, interrupts high (inactive).
  localparam dppa_state_t DPPA_STATE_RST = '{
    data: '{DPPA_REG_RST, DPPA_REG_RST}, dir: '{DPPA_REG_RST, DPPA_REG_RST},
    ctrl: '0, en_prev: 1'b0, hdout: DPPA_REG_RST, hdoe_n: 1'b1, pout: '0,
    poe_n: '1, io_out: 2'h0, io_oe_n: 2'h3, irq_n: 2'h3};

  dppa_state_t s;
  dppa_state_t nxt_s;

  logic [1:0][DPPA_W-1:0] pin_in;
  logic [3:0]             flag_lvl;
  logic [3:0]             flag_arm;
  logic [3:0]             flag_clr;
  logic [3:0]             flag;
  logic                   sel;
  logic                   acc;
  logic                   rd_data;
  logic                   port_sel;

  assign pin_in[0] = port_a_lines_in;
  assign pin_in[1] = port_b_lines_in;

  // Selection and the access strobe: one access per enable pulse, taken on its first high cycle.
  assign sel      = (host_cs == DPPA_CS_CODE);                  // see [RQ1]
  assign acc      = sel && host_en && !s.en_prev;               // see [RQ2]
  assign port_sel = host_rs[1];                                 // see [RQ7]
  assign rd_data  = acc && host_rw && !host_rs[0] && s.ctrl[port_sel][DPPA_CR_DSEL];

  // Flag inputs: entries 0 and 1 are the first control inputs, 2 and 3 the second lines.
  // The second line only raises its flag while it is configured as an input.
  assign flag_lvl = {port_b_ctrl_io_in, port_a_ctrl_io_in, port_b_ctrl_in, port_a_ctrl_in};
  assign flag_arm = {!s.ctrl[1][DPPA_CR_IOMODE], !s.ctrl[0][DPPA_CR_IOMODE], 2'b11}; // see [RQ10]

  // One capture cell per control line; a data read of a port clears both of its flags.
  for (genvar i = 0; i < 4; i++) begin : g_flag
    assign flag_clr[i] = rd_data && (port_sel == 1'(i % 2));
    dppa_flag u_flag (
      .clk   (clk),
      .rst_n (rst_n),
      .lvl   (flag_lvl[i]),
      .arm   (flag_arm[i]),
      .clr   (flag_clr[i]),
      .flag  (flag[i])
    );
  end

  // Register access and the derived pin drive; outputs are taken from next-state values
  // so that a direction write reaches the pins on the following edge.
  always_comb begin
    nxt_s         = s;
    nxt_s.en_prev = host_en;
    if (acc && !host_rw) begin                                  // see [RQ3]
      if (host_rs[0]) begin
        nxt_s.ctrl[port_sel] = host_data_in[DPPA_CR_W-1:0];
      end else if (s.ctrl[port_sel][DPPA_CR_DSEL]) begin
        nxt_s.data[port_sel] = host_data_in;
      end else begin
        nxt_s.dir[port_sel] = host_data_in;                     // see [RQ5]
      end
    end
    if (acc && host_rw) begin
      if (host_rs[0]) begin
        nxt_s.hdout = {flag[port_sel], flag[2 + port_sel], s.ctrl[port_sel]};
      end else if (s.ctrl[port_sel][DPPA_CR_DSEL]) begin
        nxt_s.hdout = (pin_in[port_sel] & ~s.dir[port_sel]) |
                      (s.data[port_sel] & s.dir[port_sel]);     // see [RQ12]
      end else begin
        nxt_s.hdout = s.dir[port_sel];
      end
    end
    // The host bus is driven for as long as a selected read enable lasts.
    nxt_s.hdoe_n = !(sel && host_en && host_rw);                // see [RQ3]
    for (int p = 0; p < 2; p++) begin
      nxt_s.pout[p]    = nxt_s.data[p];                         // see [RQ4]
      nxt_s.poe_n[p]   = ~nxt_s.dir[p];                         // see [RQ5]
      nxt_s.io_out[p]  = nxt_s.ctrl[p][DPPA_CR_IOLVL];
      nxt_s.io_oe_n[p] = !nxt_s.ctrl[p][DPPA_CR_IOMODE];        // see [RQ10]
      nxt_s.irq_n[p]   = !((flag[p] && s.ctrl[p][DPPA_CR_IN_EN]) ||
                           (flag[2 + p] && s.ctrl[p][DPPA_CR_IO_EN] &&
                            !s.ctrl[p][DPPA_CR_IOMODE]));       // see [RQ8] see [RQ9]
    end
    // Port B drivers disconnect as a group; the direction register is kept.
    if (port_b_float) begin
      nxt_s.poe_n[1] = '1;                                      // see [RQ6]
    end
  end

  // Single state register; reset zeroes data, direction and control, and sets every enable and interrupt output high.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s <= DPPA_STATE_RST;                                      // see [RQ11]
    end else begin
      s <= nxt_s;
    end
  end

  assign host_data_out       = s.hdout;
  assign host_data_oe_n      = s.hdoe_n;
  assign port_a_lines_out    = s.pout[0];
  assign port_a_lines_oe_n   = s.poe_n[0];
  assign port_b_lines_out    = s.pout[1];
  assign port_b_lines_oe_n   = s.poe_n[1];
  assign port_a_ctrl_io_out  = s.io_out[0];
  assign port_a_ctrl_io_oe_n = s.io_oe_n[0];
  assign port_b_ctrl_io_out  = s.io_out[1];
  assign port_b_ctrl_io_oe_n = s.io_oe_n[1];
  assign port_a_irq_n        = s.irq_n[0];
  assign port_b_irq_n        = s.irq_n[1];

  // Checks tying register and pin behaviour to host and line activity.
  cs_gate_a: assert property (@(posedge clk) disable iff (!rst_n)   // see [RQ1]
    (host_cs != DPPA_CS_CODE) |=> ($stable(s.data) && $stable(s.dir) && $stable(s.ctrl)))
    else $error("registers changed without a valid chip select");

  en_timing_a: assert property (@(posedge clk) disable iff (!rst_n)  // see [RQ2]
    (!host_en || s.en_prev) |=> ($stable(s.data) && $stable(s.dir) && $stable(s.ctrl)))
    else $error("registers changed outside the enable pulse edge");

  read_drive_a: assert property (@(posedge clk) disable iff (!rst_n)  // see [RQ3]
    (sel && host_en && host_rw) |=> !host_data_oe_n)
    else $error("selected read did not drive the host bus");

  bus_idle_a: assert property (@(posedge clk) disable iff (!rst_n)  // see [RQ3]
    !(sel && host_en && host_rw) |=> host_data_oe_n)
    else $error("host bus driven without a selected read");

  read_hold_a: assert property (@(posedge clk) disable iff (!rst_n)  // see [RQ3]
    !(acc && host_rw) |=> $stable(host_data_out))
    else $error("host read data changed without a read access");

  dir_write_a: assert property (@(posedge clk) disable iff (!rst_n)  // see [RQ5]
    (acc && !host_rw && host_rs == DPPA_RS_A_DATA && !s.ctrl[0][DPPA_CR_DSEL])
    |=> (port_a_lines_oe_n == ~$past(host_data_in)))
    else $error("port A direction write not reflected on pin enables");

  b_float_a: assert property (@(posedge clk) disable iff (!rst_n)  // see [RQ6]
    port_b_float |=> (port_b_lines_oe_n == 8'hFF))
    else $error("port B drivers not released while floated");

  irq_set_a: assert property (@(posedge clk) disable iff (!rst_n)  // see [RQ9]
    ($rose(port_a_ctrl_in) && s.ctrl[0][DPPA_CR_IN_EN] && !acc) ##1
    (s.ctrl[0][DPPA_CR_IN_EN] && !acc) |=> !port_a_irq_n)
    else $error("control input edge did not raise the port A interrupt");

  io_irq_a: assert property (@(posedge clk) disable iff (!rst_n)  // see [RQ10]
    ($rose(port_a_ctrl_io_in) && s.ctrl[0][DPPA_CR_IO_EN] &&
     !s.ctrl[0][DPPA_CR_IOMODE] && !acc) ##1
    (s.ctrl[0][DPPA_CR_IO_EN] && !s.ctrl[0][DPPA_CR_IOMODE] && !acc) |=> !port_a_irq_n)
    else $error("second line edge did not raise the port A interrupt");

  io_mode_a: assert property (@(posedge clk) disable iff (!rst_n)  // see [RQ10]
    (acc && !host_rw && host_rs == DPPA_RS_B_CTRL)
    |=> (port_b_ctrl_io_oe_n == !$past(host_data_in[DPPA_CR_IOMODE])))
    else $error("port B second line direction does not follow control write");

  reset_clear_a: assert property (@(posedge clk)  // see [RQ11]
    !rst_n |=> (s.data == '0 && s.dir == '0 && s.ctrl == '0 && port_a_lines_oe_n == 8'hFF
                && port_a_irq_n && port_b_irq_n))
    else $error("reset did not clear registers and release lines");

  read_mux_a: assert property (@(posedge clk) disable iff (!rst_n)  // see [RQ12]
    (acc && host_rw && host_rs == DPPA_RS_A_DATA && s.ctrl[0][DPPA_CR_DSEL])
    |=> (host_data_out == (($past(port_a_lines_in) & ~$past(s.dir[0])) |
                           ($past(s.data[0]) & $past(s.dir[0])))))
    else $error("port A data read mixes pins and stored values wrongly");
endmodule : dppa_adapter

// ===== dppa_flag.sv
// Package of shared constants for the dual port parallel adapter, and the
// edge-capture flag cell used for each control input.
// Assumes one clock, a synchronous active-low reset and pins synchronous to clk.
`timescale 1ns/1ps

package dppa_pkg;
  // Width of each peripheral port and of the host data bus.
  localparam int         DPPA_W         = 8;
  // Register-select codes: port A data or direction, A control, B data or direction, B control.
  localparam logic [1:0] DPPA_RS_A_DATA = 2'h0;
  localparam logic [1:0] DPPA_RS_A_CTRL = 2'h1;
  localparam logic [1:0] DPPA_RS_B_DATA = 2'h2;
  localparam logic [1:0] DPPA_RS_B_CTRL = 2'h3;
  // Chip-select code that makes the adapter take part in a transfer.
  localparam logic [2:0] DPPA_CS_CODE   = 3'h3;
  // Control register field positions.
  localparam int         DPPA_CR_IN_EN  = 0;
  localparam int         DPPA_CR_DSEL   = 2;
  localparam int         DPPA_CR_IOMODE = 3;
  localparam int         DPPA_CR_IOLVL  = 4;
  localparam int         DPPA_CR_IO_EN  = 5;
  localparam int         DPPA_CR_IOFLAG = 6;
  localparam int         DPPA_CR_INFLAG = 7;
  localparam int         DPPA_CR_W      = 6;
  // Reset value of every software register.
  localparam logic [7:0] DPPA_REG_RST   = 8'h00;
endpackage : dppa_pkg

module dppa_flag (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic lvl,
  input  wire logic arm,
  input  wire logic clr,
  output logic      flag
);
  typedef struct packed {
    logic prev;
    logic flag;
  } dppa_flag_t;

  dppa_flag_t s;
  dppa_flag_t nxt_s;

  // A rising level sets the flag; a set in the clearing cycle wins so no event is lost.
  always_comb begin
    nxt_s      = s;
    nxt_s.prev = lvl;
    nxt_s.flag = (arm && lvl && !s.prev) || (s.flag && !clr);
  end

  // Reset clears the flag and loads the present line level as the previous one.
  // A line that already idles high would otherwise raise a false event on release.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s <= '{prev: lvl, flag: 1'b0};
    end else begin
      s <= nxt_s;
    end
  end

  assign flag = s.flag;
endmodule : dppa_flag

// ===== dppa_host.sv
// Host processor model: drives select, read/write, enable pulse and write data.
// Assumes each access is started just after a rising clk edge.
`timescale 1ns/1ps
module dppa_host (
  input  wire logic       clk,
  output logic      [2:0] host_cs,
  output logic      [1:0] host_rs,
  output logic            host_rw,
  output logic            host_en,
  output logic      [7:0] host_data_in,
  input  wire logic [7:0] host_data_out,
  input  wire logic       host_data_oe_n
);
  // Bus drive enable seen in the same cycle as the read data of the last access.
  logic seen_oe_n;

  // The bus starts idle: not selected and enable low.
  initial begin
    host_cs      = 3'h0;
    host_rs      = 2'h0;
    host_rw      = 1'b1;
    host_en      = 1'b0;
    host_data_in = 8'h00;
    seen_oe_n    = 1'b1;
  end

  // One access; enable is held over two edges so the answer has landed when taken.
  task automatic acc(input logic [2:0] c, input logic [1:0] r, input logic w,
                     input logic [7:0] v, output logic [7:0] q);
    host_cs      = c;
    host_rs      = r;
    host_rw      = w;
    host_data_in = v;
    host_en      = 1'b1;
    repeat (2) @(posedge clk);
    #1 q = host_data_out;
    seen_oe_n    = host_data_oe_n;
    host_en      = 1'b0;
    host_cs      = 3'h0;
    host_data_in = ~v; // A released bus must not keep its last value.
    @(posedge clk);
    #1;
  endtask : acc
endmodule : dppa_host

// ===== testbench.sv
// Testbench: random and corner accesses to both ports, checked against expectations.
// Assumes the host model sits on the register side and pins resolve here.
`timescale 1ns/1ps
module testbench;
  import dppa_pkg::*;
  logic            clk = 0;
  logic            rst_n = 0;
  logic            port_b_float = 0;
  logic [1:0]      ctl_in = 2'h0;
  logic [1:0]      cio_ext = 2'h3;
  logic [7:0]      ext [2];
  logic [7:0]      seed = 8'h5D;
  logic [7:0]      r, d, e, q;
  int              n_mismatch = 0;
  int              tests_run = 0;
  wire  [2:0]      cs;
  wire  [1:0]      rs;
  wire             rw, en;
  wire  [7:0]      wd, rdat;
  wire             rd_oe_n;
  wire  [1:0][7:0] l_out, l_oe, l_in;
  wire  [1:0]      c_out, c_oe, irq;

  // Each pin shows the adapter's drive where enabled and the outside level elsewhere.
  assign l_in[0] = (l_out[0] & ~l_oe[0]) | (ext[0] & l_oe[0]);
  assign l_in[1] = (l_out[1] & ~l_oe[1]) | (ext[1] & l_oe[1]);
  always #25 clk = ~clk;

  dppa_host host (.clk(clk), .host_cs(cs), .host_rs(rs), .host_rw(rw), .host_en(en),
                  .host_data_in(wd), .host_data_out(rdat), .host_data_oe_n(rd_oe_n));
  dppa_adapter dut (.clk(clk), .rst_n(rst_n), .host_cs(cs), .host_rs(rs), .host_rw(rw),
    .host_en(en), .host_data_in(wd), .host_data_out(rdat), .host_data_oe_n(rd_oe_n),
    .port_a_lines_in(l_in[0]), .port_a_lines_out(l_out[0]), .port_a_lines_oe_n(l_oe[0]),
    .port_b_lines_in(l_in[1]), .port_b_lines_out(l_out[1]), .port_b_lines_oe_n(l_oe[1]),
    .port_b_float(port_b_float), .port_a_ctrl_in(ctl_in[0]), .port_b_ctrl_in(ctl_in[1]),
    .port_a_ctrl_io_in(c_oe[0] ? cio_ext[0] : c_out[0]), .port_a_ctrl_io_out(c_out[0]),
    .port_a_ctrl_io_oe_n(c_oe[0]), .port_b_ctrl_io_in(c_oe[1] ? cio_ext[1] : c_out[1]),
    .port_b_ctrl_io_out(c_out[1]), .port_b_ctrl_io_oe_n(c_oe[1]),
    .port_a_irq_n(irq[0]), .port_b_irq_n(irq[1]));

  // Next pseudo-random byte; a shift register keeps the run repeatable.
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr

  task automatic chk(input string nm, input logic [7:0] x, input logic [7:0] g);
    tests_run++;
    if (g !== x) begin
      $display("BAD %s expected %h seen %h", nm, x, g);
      n_mismatch++;
    end
  endtask : chk

  task automatic close_out();
    $display("mismatches %0d of %0d checks", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : close_out

  // Reset state checks shared by the start of the run and the mid-run reset.
  task automatic chk_reset();
    chk("oe_a", 8'hFF, l_oe[0]);
    chk("oe_b", 8'hFF, l_oe[1]);
    chk("out_a", 8'h00, l_out[0]);
    chk("hd_rst", 8'h00, rdat);
    chk("hd_oe", 8'h01, {7'h0, rd_oe_n});
    chk("cio_oe", 8'h03, {6'h0, c_oe});
    chk("irq", 8'h03, {6'h0, irq});
  endtask : chk_reset

  // Watchdog: the full sequence needs well under a thousand cycles.
  initial begin
    #(50 * 5000);
    n_mismatch++;
    close_out();
  end

  // Main sequence: per port direction, data, refusal, interrupt and control line.
  initial begin
    ext[0] = 8'h00;
    ext[1] = 8'h00;
    repeat (20) @(posedge clk);
    #1 rst_n = 1;
    chk_reset();
    for (int p = 0; p < 2; p++) begin
      seed = lfsr(seed); r = seed;
      seed = lfsr(seed); d = seed;
      seed = lfsr(seed); e = seed;
      ext[p] = e;
      host.acc(DPPA_CS_CODE, 2'(p * 2), 1'b0, r, q);
      host.acc(DPPA_CS_CODE, 2'(p * 2 + 1), 1'b0, 8'h05, q);
      host.acc(DPPA_CS_CODE, 2'(p * 2), 1'b0, d, q);
      chk("dir", ~r, l_oe[p]);
      chk("drive", d, l_out[p]);
      host.acc(3'h2, 2'(p * 2), 1'b0, ~d, q);
      chk("kept", d, l_out[p]);
      host.acc(DPPA_CS_CODE, 2'(p * 2), 1'b1, 8'h00, q);
      chk("read", (d & r) | (e & ~r), q);
      chk("rd_oe", 8'h00, {7'h0, host.seen_oe_n});
      // A refused read must leave the bus undriven and the last read data standing.
      host.acc(3'h2, 2'(p * 2 + 1), 1'b1, 8'h00, q);
      chk("rd_refused", (d & r) | (e & ~r), q);
      chk("rf_oe", 8'h01, {7'h0, host.seen_oe_n});
      host.acc(DPPA_CS_CODE, 2'(p * 2 + 1), 1'b1, 8'h00, q);
      chk("ctrl", 8'h05, q);
      ctl_in[p] = 1'b1;
      repeat (3) @(posedge clk);
      #1 chk("irq_set", 8'(2'b11 ^ (2'b01 << p)), {6'h0, irq});
      host.acc(DPPA_CS_CODE, 2'(p * 2), 1'b1, 8'h00, q);
      ctl_in[p] = 1'b0;
      @(posedge clk);
      #1 chk("irq_clr", 8'h03, {6'h0, irq});
      host.acc(DPPA_CS_CODE, 2'(p * 2 + 1), 1'b0, 8'h1C, q);
      chk("cio_hi", 8'h01, {6'h0, c_oe[p], c_out[p]});
      host.acc(DPPA_CS_CODE, 2'(p * 2 + 1), 1'b0, 8'h0C, q);
      chk("cio_lo", 8'h00, {6'h0, c_oe[p], c_out[p]});
      // Second line as an interrupt input: outside level low first, so only the rise counts.
      cio_ext[p] = 1'b0;
      host.acc(DPPA_CS_CODE, 2'(p * 2 + 1), 1'b0, 8'h24, q);
      chk("io_quiet", 8'h03, {6'h0, irq});
      cio_ext[p] = 1'b1;
      repeat (3) @(posedge clk);
      #1 chk("io_irq", 8'(2'b11 ^ (2'b01 << p)), {6'h0, irq});
      host.acc(DPPA_CS_CODE, 2'(p * 2), 1'b1, 8'h00, q);
      chk("io_clr", 8'h03, {6'h0, irq});
    end
    // Float held over two edges so the drive release is seen before reset hits.
    port_b_float = 1'b1;
    @(posedge clk);
    #1 chk("float", 8'hFF, l_oe[1]);
    @(posedge clk);
    #1 port_b_float = 1'b0;
    @(posedge clk);
    #1 chk("unfloat", ~r, l_oe[1]);
    rst_n = 1'b0;
    repeat (2) @(posedge clk);
    #1 rst_n = 1'b1;
    chk_reset();
    host.acc(DPPA_CS_CODE, DPPA_RS_A_CTRL, 1'b1, 8'h00, q);
    chk("ctrl_rst", DPPA_REG_RST, q);
    close_out();
  end
endmodule : testbench
